// ==== spl_pkg.sv ====
// package for the stack pointer limit checker: widths, constants and carriers
package spl_pkg;

  // ----------------------------------------
  // widths and fixed addresses
  // ----------------------------------------
  localparam int          SPL_AW          = 16;
  localparam logic [15:0] SPL_FLOOR_ADDR  = 16'h0800;  // below this lies the special register space
  localparam logic [15:0] SPL_WORD_STEP   = 16'h0002;  // one word in byte addresses
  localparam logic [15:0] SPL_SP_RST      = 16'h0800;  // pointer starts at the floor
  localparam logic [15:0] SPL_LIM_RST     = 16'hFFFE;  // arbitrary, software must load it
  localparam logic [7:0]  SPL_ZERO_BYTE   = 8'h00;

  // ----------------------------------------
  // stack operation codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SPL_OP_NONE    = 3'b000,
    SPL_OP_PUSH    = 3'b001,
    SPL_OP_POP     = 3'b010,
    SPL_OP_CALL    = 3'b011,
    SPL_OP_EXC     = 3'b100,
    SPL_OP_WR_SP   = 3'b101,
    SPL_OP_WR_LIM  = 3'b110,
    SPL_OP_EA      = 3'b111
  } spl_op_t;

  // request from the core address generator
  typedef struct packed {
    spl_op_t     op;
    logic [15:0] data;       // push data or new register value or ea
    logic [23:0] pc;         // program counter for call / exception push
    logic [7:0]  status_low_byte;
  } spl_req_t;

  // memory access produced by a push or pop
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata_lo;
    logic [15:0] wdata_hi;   // second word of a program counter push
    logic        two_words;
  } spl_mem_t;

  // trap request, separate from other trap sources
  typedef struct packed {
    logic overflow;
    logic underflow;
  } spl_trap_t;

endpackage

// ==== spl_bound_cmp.sv ====
// bounds comparator for one effective address
`timescale 1ns/1ps
module spl_bound_cmp #(
  parameter int AW = 16
) (
  input  wire logic [AW-1:0] ea_i,
  input  wire logic [AW-1:0] limit_i,
  input  wire logic [AW-1:0] floor_i,
  output logic               over_o,
  output logic               under_o
);
  // ----------------------------------------
  // compare
  // ----------------------------------------
  // an address equal to the limit is still legal
  always_comb begin
    over_o  = ea_i > limit_i;
    under_o = ea_i < floor_i;
  end
endmodule

// ==== spl_stack_check.sv ====
// software stack pointer with limit and floor checking
`timescale 1ns/1ps
// Contract
// RULE1: pointer addresses the first free word; stack grows upward.
// RULE2: push writes then adds one word; pop subtracts one word then reads.
// RULE3: call push stores program counter with upper byte cleared.
// RULE4: exception push puts status low byte in counter's upper byte.
// RULE5: limit has no defined reset value; bit zero of limit and pointer reads zero.
// RULE6: every pointer-based effective address is compared with the limit; code checks neither pops nor the second word of a counter push.
// RULE7: push at pointer equal to limit is fine; the next push traps.
// RULE8: pointer below the floor address raises an underflow trap.
// RULE9: core should not read through pointer right after a limit write.
// RULE10: trap request lasts one cycle and is separate from other traps.
module spl_stack_check #(
  parameter int AW = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire spl_pkg::spl_req_t req_i,
  output spl_pkg::spl_mem_t     mem_o,
  output spl_pkg::spl_trap_t    trap_o,
  output logic [15:0]           stack_pointer_working_reg_o,
  output logic [15:0]           stack_limit_value_o
);
  import spl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] sp;
    logic [15:0] lim;
    spl_mem_t    mem;
    spl_trap_t   trap;
  } spl_state_t;

  spl_state_t s_q, s_d;
  logic [15:0] ea;
  logic        over, under;
  logic        is_push;

  function automatic logic [15:0] align(input logic [15:0] v);
    align = {v[15:1], 1'b0};
  endfunction

  // pushes of any kind share the overflow check and the write pulse
  function automatic logic is_push_op(input spl_op_t op);
    is_push_op = (op == SPL_OP_PUSH) || (op == SPL_OP_CALL) || (op == SPL_OP_EXC);
  endfunction

  // ----------------------------------------
  // address to check
  // ----------------------------------------
  // push checks the write address, pop the predecremented one
  always_comb begin
    is_push = is_push_op(req_i.op);
    case (req_i.op)
      SPL_OP_POP: ea = s_q.sp - SPL_WORD_STEP;
      SPL_OP_EA:  ea = align(req_i.data);
      default:    ea = s_q.sp;
    endcase
  end

  spl_bound_cmp #(.AW(16)) u_cmp (
    .ea_i    (ea),
    .limit_i (s_q.lim),
    .floor_i (SPL_FLOOR_ADDR),
    .over_o  (over),
    .under_o (under)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.mem.wr = 1'b0;
    s_d.mem.rd = 1'b0;
    s_d.mem.two_words = 1'b0;
    s_d.trap = '0;
    case (req_i.op)
      SPL_OP_PUSH: begin
        s_d.mem.wr = 1'b1;
        s_d.mem.addr = s_q.sp;                          // [RULE2]
        s_d.mem.wdata_lo = req_i.data;
        s_d.sp = s_q.sp + SPL_WORD_STEP;                // [RULE1] [RULE2]
      end
      SPL_OP_CALL, SPL_OP_EXC: begin
        s_d.mem.wr = 1'b1;
        s_d.mem.two_words = 1'b1;
        s_d.mem.addr = s_q.sp;
        s_d.mem.wdata_lo = req_i.pc[15:0];
        s_d.mem.wdata_hi = (req_i.op == SPL_OP_CALL)
                         ? {SPL_ZERO_BYTE, req_i.pc[23:16]}               // [RULE3]
                         : {req_i.status_low_byte, req_i.pc[23:16]};      // [RULE4]
        s_d.sp = s_q.sp + SPL_WORD_STEP + SPL_WORD_STEP;
      end
      SPL_OP_POP: begin
        s_d.sp = s_q.sp - SPL_WORD_STEP;                // [RULE2]
        s_d.mem.rd = 1'b1;
        s_d.mem.addr = s_q.sp - SPL_WORD_STEP;
      end
      SPL_OP_WR_SP:  s_d.sp = align(req_i.data);        // [RULE5]
      SPL_OP_WR_LIM: s_d.lim = align(req_i.data);       // [RULE5]
      default: ;
    endcase
    // one-cycle trap pulse, kept apart from other trap sources
    if (req_i.op != SPL_OP_NONE && req_i.op != SPL_OP_WR_SP && req_i.op != SPL_OP_WR_LIM) begin
      s_d.trap.overflow  = over && (is_push || req_i.op == SPL_OP_EA);  // [RULE6] [RULE7] [RULE10]
      s_d.trap.underflow = under;                                       // [RULE8] [RULE10]
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // limit has no software reset meaning; a plain constant keeps sim clean
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.sp <= SPL_SP_RST;
      s_q.lim <= SPL_LIM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    mem_o = s_q.mem;
    trap_o = s_q.trap;
    stack_pointer_working_reg_o = s_q.sp;
    stack_limit_value_o = s_q.lim;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_sp_push_step: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE2]
    req_i.op == SPL_OP_PUSH |=> stack_pointer_working_reg_o == $past(stack_pointer_working_reg_o) + 16'h0002
      && mem_o.addr == $past(stack_pointer_working_reg_o)) else $error("push step wrong");
  a_sp_pop_step: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE1]
    req_i.op == SPL_OP_POP |=> mem_o.rd && mem_o.addr == stack_pointer_working_reg_o)
    else $error("pop step wrong");
  a_call_hi_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.op == SPL_OP_CALL |=> mem_o.wdata_hi[15:8] == 8'h00) else $error("call upper byte set");  // [RULE3]
  a_exc_status_in: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE4]
    req_i.op == SPL_OP_EXC |=> mem_o.wdata_hi[15:8] == $past(req_i.status_low_byte))
    else $error("status byte missing");
  a_lsb_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !stack_pointer_working_reg_o[0] && !stack_limit_value_o[0]) else $error("alignment bit set");  // [RULE5]
  a_eq_no_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.op == SPL_OP_PUSH && s_q.sp == s_q.lim |=> !trap_o.overflow) else $error("trap at limit");  // [RULE7]
  a_over_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.op == SPL_OP_PUSH && s_q.sp > s_q.lim |=> trap_o.overflow) else $error("overflow missed");  // [RULE6]
  a_under_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.op == SPL_OP_PUSH && s_q.sp < 16'h0800 |=> trap_o.underflow) else $error("underflow missed");  // [RULE8]
  a_trap_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_o.overflow && req_i.op == SPL_OP_NONE |=> !trap_o.overflow) else $error("trap not a pulse");  // [RULE10]

  // ----------------------------------------
  // step sequences
  // ----------------------------------------
  // what the core asks for at one edge, and the memory pulse that answers at the next
  sequence s_push_req;
    req_i.op == SPL_OP_PUSH;
  endsequence

  sequence s_pop_req;
    req_i.op == SPL_OP_POP;
  endsequence

  sequence s_pc_push_req;
    req_i.op == SPL_OP_CALL || req_i.op == SPL_OP_EXC;
  endsequence

  sequence s_one_word_write;
    mem_o.wr && !mem_o.rd && !mem_o.two_words;
  endsequence

  sequence s_two_word_write;
    mem_o.wr && !mem_o.rd && mem_o.two_words;
  endsequence

  sequence s_one_word_read;
    mem_o.rd && !mem_o.wr && !mem_o.two_words;
  endsequence

  // ----------------------------------------
  // memory pulses and pointer steps
  // ----------------------------------------
  a_push_wr_pulse: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE2]
    s_push_req |=> s_one_word_write) else $error("push write pulse wrong");
  a_pop_rd_pulse: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE2]
    s_pop_req |=> s_one_word_read) else $error("pop read pulse wrong");
  // a counter push takes two words, so the pointer moves by four bytes
  a_pc_push_step: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE1]
    s_pc_push_req |=> s_two_word_write ##0
      (stack_pointer_working_reg_o == $past(stack_pointer_working_reg_o) + 16'h0004))
    else $error("counter push step wrong");
  a_pc_push_lo: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE2]
    s_pc_push_req |=> mem_o.addr == $past(stack_pointer_working_reg_o)
      && mem_o.wdata_lo == $past(req_i.pc[15:0])) else $error("counter low word wrong");
  a_pc_push_hi: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE3]
    s_pc_push_req |=> mem_o.wdata_hi[7:0] == $past(req_i.pc[23:16])) else $error("counter upper byte wrong");
  // pointer only moves on a stack operation or a direct load
  a_sp_hold: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE1]
    req_i.op inside {SPL_OP_NONE, SPL_OP_WR_LIM, SPL_OP_EA}
      |=> stack_pointer_working_reg_o == $past(stack_pointer_working_reg_o)) else $error("pointer moved");
  a_lim_load: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE5]
    req_i.op == SPL_OP_WR_LIM |=> stack_limit_value_o == {$past(req_i.data[15:1]), 1'b0})
    else $error("limit load wrong");

  // ----------------------------------------
  // trap sources
  // ----------------------------------------
  // pop checks the word it is about to read, one word below the pointer
  a_pop_under_trap: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE8]
    s_pop_req ##0 (s_q.sp >= 16'h0002 && s_q.sp < 16'h0802) |=> trap_o.underflow)
    else $error("pop underflow missed");
  a_ea_over_trap: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE6]
    req_i.op == SPL_OP_EA && {req_i.data[15:1], 1'b0} > s_q.lim |=> trap_o.overflow)
    else $error("address overflow missed");
  a_ea_under_trap: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE8]
    req_i.op == SPL_OP_EA && req_i.data < 16'h0800 |=> trap_o.underflow) else $error("address underflow missed");
  // a push of any kind past the limit must trap; a pop never raises overflow
  a_any_push_over: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE6] [RULE7]
    is_push_op(req_i.op) && s_q.sp > s_q.lim |=> trap_o.overflow) else $error("push overflow missed");
  a_pop_no_over: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE10]
    s_pop_req |=> !trap_o.overflow) else $error("pop raised overflow");
  // register loads are not stack accesses and never trap
  a_load_no_trap: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE10]
    req_i.op inside {SPL_OP_NONE, SPL_OP_WR_SP, SPL_OP_WR_LIM} |=> trap_o == '0) else $error("trap without access");
  a_under_pulse: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE10]
    trap_o.underflow && req_i.op == SPL_OP_NONE |=> !trap_o.underflow) else $error("underflow not a pulse");
endmodule

// ==== spl_exc_model.sv ====
// partner model: exception logic side that takes stack trap requests
`timescale 1ns/1ps
module spl_exc_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire spl_pkg::spl_trap_t trap_i,
  output logic [7:0]              n_trap_o
);
  import spl_pkg::*;
  // ----------------------------------------
  // trap counter
  // ----------------------------------------
  // one count per high cycle, so a stretched pulse shows as extra counts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      n_trap_o <= 8'h00;
    end else if (trap_i.overflow || trap_i.underflow) begin
      n_trap_o <= n_trap_o + 8'h01;
    end
  end
endmodule

// ==== stack_pointer_limit_check_tb.sv ====
// testbench for the stack pointer limit checker
`timescale 1ns/1ps
module stack_pointer_limit_check_tb;
  import spl_pkg::*;
  typedef struct packed {
    spl_req_t    req;
    logic [15:0] sp, lim, addr, hi;
    logic [1:0]  trap;
  } spl_row_t;
  logic clk_i = 1'h0, rst_i = 1'h1;
  spl_req_t req = '0;
  spl_mem_t mem;
  spl_trap_t trap;
  logic [15:0] sp, lim;
  logic [7:0] n_trap;
  int n_errors = 0, n_compared = 0;
  spl_row_t r;
  spl_row_t rows [15] = '{
    '{'{SPL_OP_WR_LIM, 16'h0805, 24'h0, 8'h0}, 16'h0800, 16'h0804, 16'h0, 16'h0, 2'h0},
    '{'{SPL_OP_PUSH, 16'h1111, 24'h0, 8'h0}, 16'h0802, 16'h0804, 16'h0800, 16'h0, 2'h0},
    '{'{SPL_OP_PUSH, 16'h2222, 24'h0, 8'h0}, 16'h0804, 16'h0804, 16'h0802, 16'h0, 2'h0},
    '{'{SPL_OP_PUSH, 16'h3333, 24'h0, 8'h0}, 16'h0806, 16'h0804, 16'h0804, 16'h0, 2'h0},
    '{'{SPL_OP_PUSH, 16'h4444, 24'h0, 8'h0}, 16'h0808, 16'h0804, 16'h0806, 16'h0, 2'h2},
    '{'{SPL_OP_POP, 16'h0, 24'h0, 8'h0}, 16'h0806, 16'h0804, 16'h0806, 16'h0, 2'h0},
    '{'{SPL_OP_EA, 16'h0806, 24'h0, 8'h0}, 16'h0806, 16'h0804, 16'h0, 16'h0, 2'h2},
    '{'{SPL_OP_EA, 16'h0804, 24'h0, 8'h0}, 16'h0806, 16'h0804, 16'h0, 16'h0, 2'h0},
    '{'{SPL_OP_EA, 16'h07FE, 24'h0, 8'h0}, 16'h0806, 16'h0804, 16'h0, 16'h0, 2'h1},
    '{'{SPL_OP_WR_SP, 16'h0801, 24'h0, 8'h0}, 16'h0800, 16'h0804, 16'h0, 16'h0, 2'h0},
    '{'{SPL_OP_POP, 16'h0, 24'h0, 8'h0}, 16'h07FE, 16'h0804, 16'h07FE, 16'h0, 2'h1},
    '{'{SPL_OP_WR_LIM, 16'hFFFF, 24'h0, 8'h0}, 16'h07FE, 16'hFFFE, 16'h0, 16'h0, 2'h0},
    '{'{SPL_OP_WR_SP, 16'h0900, 24'h0, 8'h0}, 16'h0900, 16'hFFFE, 16'h0, 16'h0, 2'h0},
    '{'{SPL_OP_CALL, 16'h0, 24'hAB1234, 8'h5A}, 16'h0904, 16'hFFFE, 16'h0900, 16'h00AB, 2'h0},
    '{'{SPL_OP_EXC, 16'h0, 24'hAB1234, 8'h5A}, 16'h0908, 16'hFFFE, 16'h0904, 16'h5AAB, 2'h0}};

  spl_stack_check i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .mem_o(mem), .trap_o(trap),
    .stack_pointer_working_reg_o(sp), .stack_limit_value_o(lim));
  spl_exc_model i_core (.clk_i(clk_i), .rst_i(rst_i), .trap_i(trap), .n_trap_o(n_trap));

  // ----------------------------------------
  // clock, helpers and watchdog
  // ----------------------------------------
  always #50 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // requests change only just after a rising edge
  task automatic send(input spl_req_t q);
    @(posedge clk_i);
    req <= q;
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // about 63 cycles of work, so 1000 means a hang
  initial begin
    #(100 * 1000);
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    #1 chk("sp", sp, SPL_SP_RST);
    chk("lim0", 16'(lim[0]), 16'h0);
    // an idle cycle follows every request, so no read trails a limit write
    foreach (rows[i]) begin
      r = rows[i];
      send(r.req);
      send('0);
      #1 chk("sp", sp, r.sp);
      chk("lim", lim, r.lim);
      chk("trap", 16'(trap), 16'(r.trap));
      chk("wr", 16'(mem.wr), 16'(r.req.op inside {SPL_OP_PUSH, SPL_OP_CALL, SPL_OP_EXC}));
      chk("rd", 16'(mem.rd), 16'(r.req.op == SPL_OP_POP));
      chk("two", 16'(mem.two_words), 16'(r.req.op inside {SPL_OP_CALL, SPL_OP_EXC}));
      if (mem.wr || mem.rd) chk("addr", mem.addr, r.addr);
      if (r.req.op == SPL_OP_PUSH) chk("lo", mem.wdata_lo, r.req.data);
      if (r.req.op inside {SPL_OP_CALL, SPL_OP_EXC}) chk("lo", mem.wdata_lo, r.req.pc[15:0]);
      if (r.req.op inside {SPL_OP_CALL, SPL_OP_EXC}) chk("hi", mem.wdata_hi, r.hi);
    end
    $display("row tests done");
    // back to back pushes from the limit: first passes, second traps
    send('{SPL_OP_WR_LIM, 16'h0908, 24'h0, 8'h0});
    send('{SPL_OP_PUSH, 16'h5555, 24'h0, 8'h0});
    send('{SPL_OP_PUSH, 16'h6666, 24'h0, 8'h0});
    #1 chk("trap", 16'(trap), 16'h0);
    send('0);
    #1 chk("trap", 16'(trap), 16'h2);
    send('0);
    #1 chk("ntrap", 16'(n_trap), 16'h5);
    $display("back to back test done");
    // a push below the floor raises the underflow trap, not the overflow one
    send('{SPL_OP_WR_SP, 16'h07FC, 24'h0, 8'h0});
    send('{SPL_OP_PUSH, 16'h7777, 24'h0, 8'h0});
    send('0);
    #1 chk("trap", 16'(trap), 16'h1);
    chk("addr", mem.addr, 16'h07FC);
    $display("floor push test done");
    // reset in mid run puts the pointer back at the floor
    @(posedge clk_i);
    rst_i <= 1'h1;
    @(posedge clk_i);
    #1 chk("sp", sp, SPL_SP_RST);
    @(posedge clk_i);
    rst_i <= 1'h0;
    // first edge after release is quiet, the push behind it starts at the floor
    send('{SPL_OP_PUSH, 16'h8888, 24'h0, 8'h0});
    #1 chk("wr", 16'(mem.wr), 16'h0);
    chk("trap", 16'(trap), 16'h0);
    send('0);
    #1 chk("sp", sp, SPL_SP_RST + SPL_WORD_STEP);
    chk("addr", mem.addr, SPL_SP_RST);
    chk("ntrap", 16'(n_trap), 16'h0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
